// ==== hdl/tes_pkg.sv ====
// constants, field layout and register map of the t1/e1 elastic store
//
// Behaviour
// [R1] storage holds 64 bytes when both sides run e1, else 48 bytes
// [R2] incoming serial bits are captured on falling edges of the receive line clock
// [R3] outgoing serial bit changes only on rising edges of the backplane clock
// [R4] fill level is tracked; a slip happens when the store empties or fills
// [R5] a slip leaves one frame stored and happens only at a frame boundary
// [R6] receive sync rising edge sets receive frame and multiframe boundaries
// [R7] backplane sync rising edge sets backplane frame and multiframe boundaries; code restarts only the read position, no backplane multiframe count
// [R8] t1 frame is 24 channels plus framing bit, 193 bits; e1 frame 256 bits
// [R9] counters keep alignment after one sync; each later sync edge realigns
// [R10] realign low recenters at next backplane sync edge; slip if depth changes
// [R11] realign with depth already optimum makes no adjustment and no slip
// [R12] slip indicator is driven low for 65 backplane clock cycles per slip
// [R13] direction flag latched per slip: low repeated frame, high deleted frame
// [R14] multiframe marker high 65 backplane cycles at each compensated multiframe start
// [R15] each rate select picks its side independently: 0 is t1, 1 is e1
// [R16] t1 to t1: received framing bit is output right after the backplane sync
// [R17] e1 receive to t1 backplane: framing bit position outputs constant 1
// [R18] e1 backplane side has no framing bit position, channels start at boundary
// [R19] serial mode puts channel 1 data out after the backplane sync edge
// [R20] parallel mode outputs data 8 clocks earlier than serial mode
// [R21] t1 backplane drops receive channels above 24; e1 backplane passes all
// [R22] channel boundary clock goes high at every backplane channel boundary
// [R23] positions cross between clock domains only after two-flop synchronisers
package tes_pkg;

  // ------------------------------------------------------------------
  // storage and framing
  // ------------------------------------------------------------------
  localparam int         MEM_BITS       = 512;
  localparam logic [8:0] STORE_FRAME_E1 = 9'h100;  // 32 channels per stored frame
  localparam logic [8:0] STORE_FRAME_T1 = 9'h0C0;  // 24 channels per stored frame
  localparam logic [8:0] FRAME_LEN_T1   = 9'h0C1;  // 193 bit times
  localparam logic [8:0] FRAME_LEN_E1   = 9'h100;  // 256 bit times
  localparam logic [4:0] T1_CHANNELS    = 5'h18;
  localparam logic [8:0] LOOKAHEAD_BITS = 9'h008;
  localparam logic [4:0] MF_LEN_T1      = 5'h0C;
  localparam logic [4:0] MF_LEN_E1      = 5'h10;
  localparam logic [6:0] HOLD_CYCLES    = 7'h41;   // 65 backplane clocks

  // ------------------------------------------------------------------
  // synchroniser lanes
  // ------------------------------------------------------------------
  localparam int SYN_W     = 10;
  localparam int SY_RXCLK  = 0;
  localparam int SY_RXDAT  = 1;
  localparam int SY_RXSYNC = 2;
  localparam int SY_BPCLK  = 3;
  localparam int SY_BPSYNC = 4;
  localparam int SY_ALN_N  = 5;
  localparam int SY_RXRATE = 6;
  localparam int SY_BPRATE = 7;
  localparam int SY_SERIAL = 8;
  localparam int SY_SLIPIN = 9;
  localparam logic [SYN_W-1:0] SYN_RESET = 10'h320;  // realign_n, serial and slip wire idle high

  // ------------------------------------------------------------------
  // wishbone register map
  // ------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_REALIGN  = 0;
  localparam int ST_DIRECTION  = 0;
  localparam int ST_SLIP_ACT   = 1;
  localparam int ST_FRESH_LO   = 2;
  localparam int ST_MARKER     = 4;
  localparam int ST_SLIP_PIN   = 5;
  localparam int ST_COUNT_LO   = 8;

endpackage : tes_pkg

// ==== hdl/tes_elastic_store.sv ====
// two-frame t1/e1 elastic store with wishbone status/control port
`timescale 1ns/1ps
module tes_elastic_store
  import tes_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        rx_line_clock,
  input  wire logic        rx_serial_in,
  input  wire logic        rx_multiframe_sync,
  input  wire logic        rx_rate_select,
  input  wire logic        backplane_clock,
  input  wire logic        backplane_frame_sync,
  input  wire logic        backplane_rate_select,
  input  wire logic        serial_select,
  input  wire logic        realign_n,
  input  wire logic        slip_n_in,
  output logic             slip_n_out,
  output logic             slip_n_oe_n,
  output logic             direction_flag,
  output logic             backplane_serial_out,
  output logic             backplane_multiframe_marker,
  output logic             channel_boundary_clock,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [SYN_W-1:0]    sy1;
    logic [SYN_W-1:0]    sy2;
    logic [SYN_W-1:0]    sy3;
    logic                rxsync_last;
    logic                bpsync_last;
    logic [MEM_BITS-1:0] mem;
    logic [1:0]          fbit;
    logic [1:0]          mfbit;
    logic [8:0]          wpos;
    logic                wf;
    logic [4:0]          mfc;
    logic [1:0]          fresh;
    logic [8:0]          rpos;
    logic                rf;
    logic                realign_req;
    logic [6:0]          slip_cnt;
    logic [6:0]          mark_cnt;
    logic                ser_out;
    logic                chclk;
    logic                dir;
    logic                slip_oe_n;
    logic                marker;
    logic [7:0]          slips;
    logic                ack;
    logic [31:0]         dat;
  } tes_state_s;

  tes_state_s st_ff;
  tes_state_s nxt_st;

  logic       rx_e1;
  logic       sys_e1;
  logic       both_e1;
  logic [8:0] fb;
  logic [8:0] rx_len;
  logic [8:0] sys_len;
  logic [4:0] mf_len;
  logic       rx_fall;
  logic       bp_rise;
  logic       rx_sync_rise;
  logic       bp_sync_rise;
  logic [8:0] wnew;
  logic       wfr;
  logic [8:0] waddr;
  logic       wr_done;
  logic       mf_start;
  logic [8:0] rnew;
  logic       boundary;
  logic       sel_rf;
  logic       slip_now;
  logic       slip_dir_now;
  logic       realign_served;
  logic [8:0] dpos;
  logic [8:0] rbase;
  logic [8:0] dlow;
  logic       obit;
  logic [1:0] fr;
  logic       wb_req;

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_st         = st_ff;
    wnew           = st_ff.wpos;
    wfr            = st_ff.wf;
    waddr          = 9'h000;
    wr_done        = 1'b0;
    mf_start       = 1'b0;
    rnew           = st_ff.rpos;
    boundary       = 1'b0;
    sel_rf         = st_ff.rf;
    slip_now       = 1'b0;
    slip_dir_now   = st_ff.dir;
    realign_served = 1'b0;
    dpos           = 9'h000;
    rbase          = 9'h000;
    dlow           = 9'h000;
    obit           = 1'b1;
    fr             = st_ff.fresh;

    // both line clocks and all line-side pins pass two flops before use
    nxt_st.sy1 = {slip_n_in, serial_select, backplane_rate_select, rx_rate_select,
                  realign_n, backplane_frame_sync, backplane_clock,
                  rx_multiframe_sync, rx_serial_in, rx_line_clock};  // R23
    nxt_st.sy2 = st_ff.sy1;
    nxt_st.sy3 = st_ff.sy2;

    // rate choice per side, storage sized from the pair
    rx_e1   = st_ff.sy2[SY_RXRATE];  // R15
    sys_e1  = st_ff.sy2[SY_BPRATE];  // R15
    both_e1 = rx_e1 & sys_e1;
    fb      = both_e1 ? STORE_FRAME_E1 : STORE_FRAME_T1;  // R1
    rx_len  = rx_e1 ? FRAME_LEN_E1 : FRAME_LEN_T1;  // R8
    sys_len = sys_e1 ? FRAME_LEN_E1 : FRAME_LEN_T1;  // R8
    mf_len  = rx_e1 ? MF_LEN_E1 : MF_LEN_T1;

    // edges found by the system clock on the second synchroniser stage
    rx_fall = st_ff.sy3[SY_RXCLK] & ~st_ff.sy2[SY_RXCLK];  // R2
    bp_rise = ~st_ff.sy3[SY_BPCLK] & st_ff.sy2[SY_BPCLK];  // R3
    rx_sync_rise = rx_fall & st_ff.sy2[SY_RXSYNC] & ~st_ff.rxsync_last;
    bp_sync_rise = bp_rise & st_ff.sy2[SY_BPSYNC] & ~st_ff.bpsync_last;

    // write side: one bit per falling line clock edge
    if (rx_fall)
    begin
      nxt_st.rxsync_last = st_ff.sy2[SY_RXSYNC];
      if (rx_sync_rise || st_ff.wpos == rx_len - 9'h001)
        wnew = 9'h000;  // R6 R9
      else
        wnew = st_ff.wpos + 9'h001;
      nxt_st.wpos = wnew;
      if (wnew == 9'h000)
      begin
        wr_done  = 1'b1;
        wfr      = ~st_ff.wf;
        mf_start = rx_sync_rise | (st_ff.mfc == mf_len - 5'h01);  // R6
        nxt_st.wf  = wfr;
        nxt_st.mfc = mf_start ? 5'h00 : st_ff.mfc + 5'h01;
        nxt_st.mfbit[wfr] = mf_start;
      end
      if (!rx_e1)
      begin
        if (wnew == 9'h000)
          nxt_st.fbit[wfr] = st_ff.sy2[SY_RXDAT];  // R16
        else
        begin
          waddr = (wfr ? fb : 9'h000) + wnew - 9'h001;
          nxt_st.mem[waddr] = st_ff.sy2[SY_RXDAT];  // R2
        end
      end
      else if (both_e1 || wnew < STORE_FRAME_T1)
      begin
        // channels past 24 are dropped when the backplane is t1
        waddr = (wfr ? fb : 9'h000) + wnew;  // R21
        nxt_st.mem[waddr] = st_ff.sy2[SY_RXDAT];
      end
    end

    // read side: position advances on each rising backplane edge
    if (bp_rise)
    begin
      nxt_st.bpsync_last = st_ff.sy2[SY_BPSYNC];
      if (bp_sync_rise || st_ff.rpos == sys_len - 9'h001)
        rnew = 9'h000;  // R7 R9
      else
        rnew = st_ff.rpos + 9'h001;
      nxt_st.rpos = rnew;
      boundary = (rnew == 9'h000);
    end

    // frame boundary: choose the frame to replay and judge the depth
    if (boundary)
    begin
      realign_served = st_ff.realign_req & bp_sync_rise;  // R10
      if (st_ff.fresh == 2'h0)
      begin
        // nothing new arrived: the store ran empty, repeat a frame
        slip_now     = 1'b1;  // R4 R5
        slip_dir_now = 1'b0;  // R13
      end
      else
      begin
        sel_rf = ~st_ff.wf;  // newest complete frame leaves one frame stored
        if (st_ff.fresh == 2'h2)
        begin
          slip_now     = 1'b1;  // R4 R5
          slip_dir_now = 1'b1;  // R13
        end
      end
      // fresh of one means the depth is already optimum: no slip
      if (realign_served)
        nxt_st.realign_req = 1'b0;  // R11
      nxt_st.rf = sel_rf;
      if (st_ff.mfbit[sel_rf])
      begin
        nxt_st.mark_cnt = HOLD_CYCLES;  // R14
        nxt_st.marker   = 1'b1;
      end
      fr = 2'h0;
    end
    else if (bp_rise && st_ff.mark_cnt != 7'h00)
    begin
      nxt_st.mark_cnt = st_ff.mark_cnt - 7'h01;
      nxt_st.marker   = (st_ff.mark_cnt != 7'h01);  // R14
    end

    // a frame finishing in the boundary cycle still counts
    if (wr_done && fr != 2'h2)
      fr = fr + 2'h1;
    nxt_st.fresh = fr;  // R4

    // request a realign from the pin level or from software
    if (!st_ff.sy2[SY_ALN_N])
      nxt_st.realign_req = 1'b1;  // R10

    // slip indicator and direction latch
    if (slip_now)
    begin
      nxt_st.slip_cnt  = HOLD_CYCLES;  // R12
      nxt_st.slip_oe_n = 1'b0;
      nxt_st.dir       = slip_dir_now;  // R13
      nxt_st.slips     = st_ff.slips + 8'h01;
    end
    else if (bp_rise && st_ff.slip_cnt != 7'h00)
    begin
      nxt_st.slip_cnt  = st_ff.slip_cnt - 7'h01;
      nxt_st.slip_oe_n = (st_ff.slip_cnt == 7'h01);  // R12
    end

    // output bit: parallel mode looks 8 bits ahead
    if (bp_rise)
    begin
      if (st_ff.sy2[SY_SERIAL])
        dpos = rnew;  // R19
      else if (rnew + LOOKAHEAD_BITS >= sys_len)
        dpos = rnew + LOOKAHEAD_BITS - sys_len;  // R20
      else
        dpos = rnew + LOOKAHEAD_BITS;  // R20
      rbase = sel_rf ? fb : 9'h000;
      if (sys_e1)
      begin
        dlow = dpos;  // R18
        // a t1 receive side has nothing for channels 25 to 32
        if (!both_e1 && dpos[7:3] >= T1_CHANNELS)
          obit = 1'b1;
        else
          obit = st_ff.mem[rbase + dpos];
        nxt_st.chclk = ~dlow[2];  // R22
      end
      else if (dpos == 9'h000)
      begin
        obit = rx_e1 ? 1'b1 : st_ff.fbit[sel_rf];  // R16 R17
        nxt_st.chclk = 1'b0;
      end
      else
      begin
        dlow = dpos - 9'h001;
        obit = st_ff.mem[rbase + dlow];
        nxt_st.chclk = ~dlow[2];  // R22
      end
      nxt_st.ser_out = obit;  // R3
    end

    // wishbone classic slave, one wait-free ack per request
    wb_req     = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    nxt_st.ack = wb_req;
    nxt_st.dat = 32'h0000_0000;
    if (wb_req && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_REALIGN])
      nxt_st.realign_req = 1'b1;  // R10
    if (wb_req && !wb_we_i)
    begin
      if (wb_adr_i == REG_CTRL)
        nxt_st.dat[CTRL_REALIGN] = st_ff.realign_req;
      else if (wb_adr_i == REG_STATUS)
      begin
        nxt_st.dat[ST_DIRECTION]            = st_ff.dir;
        nxt_st.dat[ST_SLIP_ACT]             = ~st_ff.slip_oe_n;
        nxt_st.dat[ST_FRESH_LO +: 2]        = st_ff.fresh;
        nxt_st.dat[ST_MARKER]               = st_ff.marker;
        nxt_st.dat[ST_SLIP_PIN]             = st_ff.sy2[SY_SLIPIN];
        nxt_st.dat[ST_COUNT_LO +: 8]        = st_ff.slips;
      end
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff           <= '0;
      st_ff.sy1       <= SYN_RESET;
      st_ff.sy2       <= SYN_RESET;
      st_ff.sy3       <= SYN_RESET;
      st_ff.ser_out   <= 1'b1;
      st_ff.slip_oe_n <= 1'b1;
      st_ff.fresh     <= 2'h1;
    end
    else
      st_ff <= nxt_st;
  end

  // every output straight from a flip-flop except slip_n_out, tied low
  assign slip_n_out                  = 1'b0;
  assign slip_n_oe_n                 = st_ff.slip_oe_n;
  assign direction_flag              = st_ff.dir;
  assign backplane_serial_out        = st_ff.ser_out;
  assign backplane_multiframe_marker = st_ff.marker;
  assign channel_boundary_clock      = st_ff.chclk;
  assign wb_dat_o                    = st_ff.dat;
  assign wb_ack_o                    = st_ff.ack;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_slip_start;
    slip_now;
  endsequence

  sequence s_slip_shown;
    !slip_n_oe_n && (st_ff.slip_cnt == HOLD_CYCLES);
  endsequence

  AST_SLIP_LOW: assert property (s_slip_start |=> s_slip_shown) // R12
    else $error("slip indicator not driven low with full hold count");
  AST_SLIP_RELEASE: assert property ($rose(slip_n_oe_n) |-> $past(st_ff.slip_cnt) == 7'h01
                                     && $past(bp_rise)) // R12
    else $error("slip indicator released before 65 backplane clocks");
  AST_SLIP_FRAME: assert property (slip_now |-> bp_rise && rnew == 9'h000) // R5
    else $error("slip outside a frame boundary");
  AST_DIR_LATCH: assert property (slip_now |=> direction_flag == $past(slip_dir_now)) // R13
    else $error("direction flag not latched at slip");
  AST_MARK_HOLD: assert property ($fell(backplane_multiframe_marker) |->
                                  $past(st_ff.mark_cnt) == 7'h01) // R14
    else $error("multiframe marker dropped early");
  AST_OUT_RISE: assert property ($changed(backplane_serial_out) |-> $past(bp_rise)) // R3
    else $error("serial output changed without backplane rising edge");
  AST_RX_FALL: assert property ($changed(st_ff.wpos) |-> $past(rx_fall)) // R2
    else $error("write position moved without line clock falling edge");
  AST_RX_SYNC: assert property (rx_sync_rise |=> st_ff.wpos == 9'h000) // R6
    else $error("receive sync did not realign write position");
  AST_BP_SYNC: assert property (bp_sync_rise |=> st_ff.rpos == 9'h000) // R7
    else $error("backplane sync did not realign read position");
  AST_FBIT_ONE: assert property (bp_rise && rx_e1 && !sys_e1 && dpos == 9'h000
                                 |=> backplane_serial_out) // R17
    else $error("framing position not forced to one");
  // one bit wider so two 256-bit frames do not wrap the bound to zero
  AST_CAPACITY: assert property (rx_fall |-> {1'b0, waddr} < {fb, 1'b0}) // R1
    else $error("write address beyond store capacity");
  AST_REALIGN_QUIET: assert property (realign_served && st_ff.fresh == 2'h1 |-> !slip_now) // R11
    else $error("slip reported on realign at optimum depth");

endmodule : tes_elastic_store

// ==== test/tes_line_partner.sv ====
// line-side partner: receive framer and backplane timing source
`timescale 1ns/1ps
module tes_line_partner
(
  input  wire logic rx_rate,
  input  wire logic bp_rate,
  input  wire logic restart,
  input  int        bp_half,
  output logic      rx_clk,
  output logic      rx_ser,
  output logic      rx_sync,
  output logic      bp_clk,
  output logic      bp_sync,
  output int        bp_pos
);
  int rx_pos = 0;
  int bp_nxt = 0;
  bit rx_req = 1'h0;
  // ------------------------------------------------------------------
  // frame content: every frame alike, so a slip never corrupts data
  // ------------------------------------------------------------------
  function automatic logic [7:0] ch_byte(input int ch);
    return 8'(ch * 37 + 5);
  endfunction : ch_byte

  function automatic logic rx_bit(input int p);
    logic [7:0] b;
    b = ch_byte((rx_rate ? p : p - 1) / 8 + 1);
    if (!rx_rate && p == 0)
      return 1'h0;  // framing bit sent as 0
    return b[7 - (rx_rate ? p : p - 1) % 8];
  endfunction : rx_bit

  // receive line: data moves after a rising edge, held across the falling edge
  always
  begin
    #62.5 rx_clk = 1'h1;
    if (rx_req)
      rx_pos = 0;
    rx_ser  = rx_bit(rx_pos);
    rx_sync = rx_req;  // one pulse marks bit 0; counters carry on alone
    rx_req  = 1'h0;
    #62.5 rx_clk = 1'h0;
    rx_pos = (rx_pos + 1) % (rx_rate ? 256 : 193);
  end

  always @(posedge restart) rx_req = 1'h1;

  // backplane: sync moves on falling edges so it is stable at each rising edge
  always
  begin
    #(bp_half) bp_clk = 1'h1;
    bp_pos = bp_nxt;
    #(bp_half) bp_clk = 1'h0;
    bp_nxt  = (bp_pos + 1) % (bp_rate ? 256 : 193);
    bp_sync = (bp_nxt == 0);
  end

  initial {rx_clk, rx_ser, rx_sync, bp_clk, bp_sync} = 5'h04;
endmodule : tes_line_partner

// ==== test/test_t1_e1_elastic_store.sv ====
// self-checking bench for the t1/e1 elastic store
`timescale 1ns/1ps
module test_t1_e1_elastic_store
  import tes_pkg::*;
();
  logic        clock = 1'h0;
  logic        reset_n = 1'h0;
  logic        rx_rate = 1'h0;
  logic        bp_rate = 1'h0;
  logic        serial_sel = 1'h1;
  logic        realign_n = 1'h1;
  logic        restart = 1'h0;
  logic        wb_cyc = 1'h0;
  logic        wb_stb = 1'h0;
  logic        wb_we = 1'h0;
  logic [3:0]  wb_adr = 4'h0;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack, rx_clk, rx_ser, rx_sync, bp_clk, bp_sync, slip_out, slip_oe_n;
  logic        dir_flag, ser_out, marker, chan_clk;
  wire         slip_wire = slip_oe_n ? 1'h1 : slip_out;  // pulled-up open-drain wire
  int          bp_half = 62;
  int          bp_pos, fails = 0, checks = 0, cycles = 0;

  // 250 MHz system clock
  always #2 clock = ~clock;

  tes_elastic_store i_tes_elastic_store
  (
    .clock(clock), .reset_n(reset_n), .rx_line_clock(rx_clk), .rx_serial_in(rx_ser),
    .rx_multiframe_sync(rx_sync), .rx_rate_select(rx_rate), .backplane_clock(bp_clk),
    .backplane_frame_sync(bp_sync), .backplane_rate_select(bp_rate),
    .serial_select(serial_sel), .realign_n(realign_n), .slip_n_in(slip_wire),
    .slip_n_out(slip_out), .slip_n_oe_n(slip_oe_n), .direction_flag(dir_flag),
    .backplane_serial_out(ser_out), .backplane_multiframe_marker(marker),
    .channel_boundary_clock(chan_clk), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack)
  );

  tes_line_partner i_tes_line_partner
  (
    .rx_rate(rx_rate), .bp_rate(bp_rate), .restart(restart), .bp_half(bp_half),
    .rx_clk(rx_clk), .rx_ser(rx_ser), .rx_sync(rx_sync), .bp_clk(bp_clk),
    .bp_sync(bp_sync), .bp_pos(bp_pos)
  );

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // one classic wishbone cycle; request held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    @(posedge clock);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {2'h3, we, adr, 4'hF, wd};
    // no latency assumed: only the run ceiling ends a lost answer
    do @(posedge clock); while (wb_ack !== 1'h1);
    rd = wb_rdat;
    {wb_cyc, wb_stb, wb_we, wb_sel} <= 7'h00;
    @(posedge clock);
    check("wb_ack", wb_ack, 1'h0);  // ack stands a single cycle
  endtask : wb_xfer

  task automatic wait_frames(input int n);
    repeat (n) do @(negedge bp_clk); while (bp_pos != 0);
  endtask : wait_frames

  // counts backplane edges while a pulse stands: marker high or slip driven low
  task automatic pulse_len(input logic of_marker, output int w);
    w = 0;
    @(negedge bp_clk);
    while ((of_marker ? marker : !slip_oe_n) === 1'h1 && w < 100)
    begin
      w++;
      @(negedge bp_clk);
    end
  endtask : pulse_len

  // compares one backplane frame, sampled mid-bit where the output has settled
  task automatic compare_frame();
    int         len, p, q;
    logic [7:0] b;
    logic       e;
    len = bp_rate ? 256 : 193;
    do @(negedge bp_clk); while (bp_pos != 0);
    for (int n = 0; n < len; n++)
    begin
      p = serial_sel ? n : (n + 8) % len;  // look-ahead runs eight bits early
      q = bp_rate ? p : p - 1;
      b = i_tes_line_partner.ch_byte(q / 8 + 1);
      e = (q < 0) ? rx_rate : b[7 - q % 8];  // carried or forced framing bit
      if (!rx_rate && q > 191)
        e = 1'h1;  // a t1 source leaves channels 25 to 32 at 1
      check("serial_out", ser_out, e);
      if (serial_sel)
        check("chan_clk", chan_clk, q >= 0 && q % 8 < 4);
      @(negedge bp_clk);
    end
  endtask : compare_frame

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_reset();
    logic [31:0] rd;
    check("slip_oe_n", slip_oe_n, 1'h1);
    check("marker", marker, 1'h0);
    check("direction", dir_flag, 1'h0);
    wb_xfer(1'h0, REG_STATUS, 32'h0, rd);
    check("fill", rd[3:2], 2'h1);
    wb_xfer(1'h1, 4'hC, 32'hFFFFFFFF, rd);
    wb_xfer(1'h0, 4'hC, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_t1();
    int n, w;
    @(posedge clock);
    restart <= 1'h1;
    @(posedge clock);
    restart <= 1'h0;
    n = 0;
    while (marker !== 1'h1 && n < 40000)
    begin
      @(posedge clock);
      n++;
    end
    check("marker_pos", bp_pos, 0);
    pulse_len(1'h1, w);
    check("marker_len", w, 65);
    compare_frame();
    @(posedge clock);
    serial_sel <= 1'h0;
    compare_frame();
    @(posedge clock);
    serial_sel <= 1'h1;
    $display("test t1 to t1 done");
  endtask : test_t1

  // a read side faster or slower than the line forces a slip
  task automatic test_slip(input int half, input logic exp_dir);
    logic [31:0] rd;
    logic [7:0]  c0;
    int          n, w;
    bp_half = half;
    wb_xfer(1'h0, REG_STATUS, 32'h0, rd);
    c0 = rd[15:8];
    n = 0;
    while (slip_oe_n !== 1'h0 && n < 80000)
    begin
      @(posedge clock);
      n++;
    end
    check("slip_pos", bp_pos, 0);
    check("slip_dir", dir_flag, exp_dir);
    check("slip_wire", slip_wire, 1'h0);
    pulse_len(1'h0, w);
    check("slip_len", w, 65);
    wb_xfer(1'h0, REG_STATUS, 32'h0, rd);
    check("slip_cnt", rd[15:8], c0 + 8'h01);
    check("slip_stat", rd[1:0], {1'h0, exp_dir});
    check("slip_pin", rd[5], 1'h1);
    $display("test slip direction %0d done", exp_dir);
  endtask : test_slip

  // realign by pin, then by register, while the depth is already one frame
  task automatic test_realign();
    logic [31:0] rd;
    logic [7:0]  c0;
    bp_half = 62;
    wait_frames(2);
    wb_xfer(1'h0, REG_STATUS, 32'h0, rd);
    c0 = rd[15:8];
    @(posedge clock);
    realign_n <= 1'h0;
    wait_frames(1);
    @(posedge clock);
    realign_n <= 1'h1;
    wb_xfer(1'h1, REG_CTRL, 32'h1, rd);
    wb_xfer(1'h0, REG_CTRL, 32'h0, rd);
    check("align_wait", rd[0], 1'h1);
    wait_frames(1);
    wb_xfer(1'h0, REG_CTRL, 32'h0, rd);
    check("align_done", rd[0], 1'h0);
    // fill is read late in the frame, after this frame's write has completed
    do @(negedge bp_clk); while (bp_pos != 192);
    wb_xfer(1'h0, REG_STATUS, 32'h0, rd);
    check("align_cnt", rd[15:8], c0);
    check("align_fill", rd[3:2], 2'h1);
    $display("test realign done");
  endtask : test_realign

  task automatic test_rates();
    // k of 3 runs both sides e1, the only mode with the 64-byte store
    for (int k = 1; k < 4; k++)
    begin
      @(posedge clock);
      {rx_rate, bp_rate} <= 2'(k);
      restart <= 1'h1;
      @(posedge clock);
      restart <= 1'h0;
      wait_frames(2);
      compare_frame();
      $display("test rates %0d done", k);
    end
  endtask : test_rates

  // ceiling about twice the cycles the sequence needs
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 300000)
    begin
      fails = fails + 1;
      finish_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge clock);
    reset_n <= 1'h1;
    test_reset();
    test_t1();
    test_slip(50, 1'h0);
    test_slip(125, 1'h1);
    test_realign();
    test_rates();
    finish_test();
  end
endmodule : test_t1_e1_elastic_store
